// file: bench/card_pair.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// two controller cards and the remote lamp circuits
// ****
module card_pair (
  input wire logic ref_clk,
  input wire logic want_sane_a,
  input wire logic want_sane_b,
  input wire logic want_master_b,
  input wire logic [2:0] lamp_broken,
  input wire logic [2:0] remote_maintenance_alarm,
  output logic sane_a_pin,
  output logic sane_b_pin,
  output logic master_b_pin,
  output logic [2:0] lamp_sense_pin
);
  // a hung card simply stops asserting its health line
  always @(posedge ref_clk) begin
    sane_a_pin <= want_sane_a;
    sane_b_pin <= want_sane_b;
    master_b_pin <= want_master_b;
    // current flows only through a driven circuit with an intact bulb
    lamp_sense_pin <= remote_maintenance_alarm & ~lamp_broken;
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "alarm_relay_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic ref_clk, nrst, reg_wr, reg_rd, reg_card, rd_d;
  logic [7:0] reg_addr, x;
  logic [31:0] reg_wdata, reg_rdata, rs, r, e_rd;
  logic sane_a_pin, sane_b_pin, master_b_pin, want_sane_a, want_sane_b, want_master_b, irq, audible_alarm;
  logic [2:0] lamp_sense_pin, lamp_broken, remote_maintenance_alarm, local_maintenance_alarm;
  logic [5:0] rack_critical_quiet, rack_major, rack_minor, fan_relay;
  logic row_end_critical_quiet, row_end_major, row_end_minor;
  logic [17:0] rk;
  logic [31:0] q[$];
  logic [7:0] aux_tab[5] = '{8'h01, 8'h1C, 8'h1E, 8'hE0, 8'hFF};
  int n_mismatch = 0;
  int checked = 0;
  int i;
  alarm_relay_control i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_card(reg_card), .reg_rdata(reg_rdata), .sane_a_pin(sane_a_pin),
    .sane_b_pin(sane_b_pin), .master_b_pin(master_b_pin), .lamp_sense_pin(lamp_sense_pin),
    .rack_critical_quiet(rack_critical_quiet), .rack_major(rack_major), .rack_minor(rack_minor),
    .row_end_critical_quiet(row_end_critical_quiet), .row_end_major(row_end_major),
    .row_end_minor(row_end_minor), .audible_alarm(audible_alarm),
    .remote_maintenance_alarm(remote_maintenance_alarm), .local_maintenance_alarm(local_maintenance_alarm),
    .fan_relay(fan_relay), .irq(irq));
  card_pair i_cards (.ref_clk(ref_clk), .want_sane_a(want_sane_a), .want_sane_b(want_sane_b),
    .want_master_b(want_master_b), .lamp_broken(lamp_broken), .remote_maintenance_alarm(remote_maintenance_alarm),
    .sane_a_pin(sane_a_pin), .sane_b_pin(sane_b_pin), .master_b_pin(master_b_pin),
    .lamp_sense_pin(lamp_sense_pin));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] exp_rs(input logic [17:0] v, input logic [7:0] a, input logic s);
    logic [17:0] k;
    logic [2:0] re, lc, rm;
    re = 3'h0;
    for (int j = 0; j < 6; j++) begin
      k[3*j+2] = v[3*j+2] | ~s;
      k[3*j+1] = v[3*j+1] & s;
      k[3*j] = v[3*j] & s;
      re = re | k[3*j+:3];
    end
    lc = {a[7] | ~s, a[6:5] & {s, s}};
    rm = a[1] ? {a[4] | ~s, a[3:2] & {s, s}} : 3'h0;
    return {4'h0, k, re, a[0] | ~s, rm, lc};
  endfunction
  function automatic logic [5:0] lv(input logic [17:0] v, input int b);
    logic [5:0] o;
    for (int j = 0; j < 6; j++) o[j] = v[3*j+b];
    return o;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_card <= c;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic c, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_card <= c;
    reg_addr <= a;
    q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d === 1'b1) begin
      e_rd = q.pop_front();
      `CHK("rdata", e_rd, reg_rdata)
    end
    rd_d <= reg_rd;
  end
  // ****
  // scenarios
  // ****
  initial begin
    nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_card = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    want_sane_a = 1'b1; want_sane_b = 1'b1; want_master_b = 1'b0; lamp_broken = 3'h0; rs = 32'h626A;
    cyc(12);
    nrst <= 1'b1;
    cyc(6);
    rd(0, `OFF_RELAY_STATE, exp_rs(18'h0, 8'h0, 1'b1));
    rd(1, `OFF_FAN, 32'h0);
    rd(0, `OFF_CARD_STATE, 32'h3);
    `CHK("quiet", 6'h3F, rack_critical_quiet)
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      r = xs();
      rk = r[17:0];
      wr(0, `OFF_RACK_REQ, {14'h0, rk});
      rd(0, `OFF_RELAY_STATE, exp_rs(rk, 8'h0, 1'b1));
      rd(1, `OFF_RELAY_STATE, exp_rs(rk, 8'h0, 1'b1));
      `CHK("quiet", ~lv(rk, 2), rack_critical_quiet)
      `CHK("major", lv(rk, 1), rack_major)
      `CHK("minor", lv(rk, 0), rack_minor)
      `CHK("re_crit", ~|lv(rk, 2), row_end_critical_quiet)
      `CHK("re_lvls", {|lv(rk, 1), |lv(rk, 0)}, {row_end_major, row_end_minor})
    end
    wr(1, `OFF_RACK_REQ, {14'h0, ~rk});
    rd(0, `OFF_RELAY_STATE, exp_rs(rk, 8'h0, 1'b1));
    rd(1, `OFF_RACK_REQ, {14'h0, ~rk});
    want_master_b <= 1'b1;
    cyc(6);
    rd(0, `OFF_RELAY_STATE, exp_rs(~rk, 8'h0, 1'b1));
    rd(1, `OFF_CARD_STATE, 32'h7);
    want_master_b <= 1'b0;
    cyc(6);
    $display("test master done");
    want_sane_a <= 1'b0;
    cyc(6);
    rd(0, `OFF_RELAY_STATE, exp_rs(rk, 8'h0, 1'b1));
    want_sane_b <= 1'b0;
    cyc(6);
    rd(0, `OFF_RELAY_STATE, exp_rs(rk, 8'h0, 1'b0));
    `CHK("quiet", 6'h00, rack_critical_quiet)
    `CHK("audible", 1'b1, audible_alarm)
    want_sane_a <= 1'b1;
    want_sane_b <= 1'b1;
    cyc(6);
    $display("test sanity done");
    for (i = 0; i < 5; i++) begin
      x = aux_tab[i];
      wr(0, `OFF_AUX_REQ, {24'h0, x});
      rd(0, `OFF_RELAY_STATE, exp_rs(rk, x, 1'b1));
      `CHK("remote", x[1] ? x[4:2] : 3'h0, remote_maintenance_alarm)
      `CHK("local", x[7:5], local_maintenance_alarm)
    end
    $display("test aux done");
    r = xs();
    wr(0, `OFF_FAN, {26'h0, r[5:0]});
    cyc(1);
    `CHK("fan", r[5:0], fan_relay)
    wr(1, `OFF_FAN, {26'h0, ~r[5:0]});
    cyc(1);
    `CHK("fan", r[5:0], fan_relay)
    rd(0, 8'h1C, 32'h0);
    $display("test fan done");
    wr(0, `OFF_AUX_REQ, 32'h1E);
    wr(0, `OFF_LAMP_MASK, 32'h4);
    wr(1, `OFF_LAMP_MASK, 32'h3);
    rd(1, `OFF_LAMP_MASK, 32'h4);
    lamp_broken <= 3'h4;
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge ref_clk);
    if (irq !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] irq exp 1 got %b", irq);
      stop_test();
    end
    rd(1, `OFF_LAMP_STATUS, 32'h4);
    wr(0, `OFF_LAMP_STATUS, 32'h4);
    rd(0, `OFF_LAMP_STATUS, 32'h4);
    lamp_broken <= 3'h0;
    wr(0, `OFF_LAMP_MASK, 32'h0);
    cyc(1);
    `CHK("irq", 1'b0, irq)
    wr(0, `OFF_LAMP_STATUS, 32'h4);
    rd(0, `OFF_LAMP_STATUS, 32'h0);
    cyc(2);
    $display("test lamp done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: core/alarm_pkg.sv
`include "alarm_relay_cfg.svh"
package alarm_pkg;
  typedef struct packed {
    logic critical;
    logic major;
    logic minor;
  } level_t;

  typedef level_t [`RACK_COUNT-1:0] rack_levels_t;

  typedef struct packed {
    level_t local_lvl;
    level_t remote;
    logic gate;
    logic audible;
  } aux_req_t;

  typedef struct packed {
    rack_levels_t rack;
    aux_req_t aux;
  } card_req_t;

  typedef struct packed {
    rack_levels_t rack;
    level_t row_end;
    logic audible;
    level_t remote;
    level_t local_lvl;
  } relay_state_t;
endpackage

// file: core/alarm_relay_cfg.svh
// Notes on behaviour
// R1: per-rack critical, major, minor outputs, six racks
// R2: one software-controlled audible alarm output
// R3: rack, remote, local, row-end alarm groups
// R4: outputs follow requests, gated; critical fail-safe
// R5: relay state readable by both cards always
// R6: fan relays change only by software writes; nrst also clears them here
// R7: critical drive de-energised means alarming
// R8: major/minor need request and one sane card
// R9: critical on request or both cards insane
// R10: transfer gate on passes remote alarms
// R11: transfer gate off blocks remote alarms
// R12: remote alarm on, no current: lamp failure
// R13: fan relays individually settable per frame
// R14: master drives outputs, both cards read
// R15: audible: both insane, or sane and requested
// R16: each card signals its own sanity
// R17: lamp failure latched until software clears
`ifndef ALARM_RELAY_CFG_SVH
`define ALARM_RELAY_CFG_SVH

// ****************************************
// sizes
// ****************************************
`define RACK_COUNT 6
`define FAN_COUNT 6
`define LEVEL_COUNT 3
`define REG_ADDR_W 8
`define REG_DATA_W 32

// ****************************************
// register offsets
// ****************************************
`define OFF_RACK_REQ 8'h00
`define OFF_AUX_REQ 8'h04
`define OFF_FAN 8'h08
`define OFF_RELAY_STATE 8'h0C
`define OFF_LAMP_STATUS 8'h10
`define OFF_LAMP_MASK 8'h14
`define OFF_CARD_STATE 8'h18

// ****************************************
// field positions
// ****************************************
`define AUX_AUDIBLE_BIT 0
`define AUX_GATE_BIT 1
`define AUX_REMOTE_LSB 2
`define AUX_LOCAL_LSB 5
`define CARD_SANE_A_BIT 0
`define CARD_SANE_B_BIT 1
`define CARD_MASTER_BIT 2

// ****************************************
// reset values
// ****************************************
`define RACK_REQ_RST 18'h00000
`define AUX_REQ_RST 8'h00
`define FAN_RST 6'h00
`define LAMP_MASK_RST 3'h0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 10
`define LAMP_SETTLE_NS 1000
`define LAMP_SETTLE_CYC ((`LAMP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LAMP_CNT_W 7

`endif

// file: core/alarm_relay_control.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_relay_cfg.svh"
module alarm_relay_control
  import alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [`REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_card,
  output logic [`REG_DATA_W-1:0] reg_rdata,
  input wire logic sane_a_pin,
  input wire logic sane_b_pin,
  input wire logic master_b_pin,
  input wire logic [`LEVEL_COUNT-1:0] lamp_sense_pin,
  output logic [`RACK_COUNT-1:0] rack_critical_quiet,
  output logic [`RACK_COUNT-1:0] rack_major,
  output logic [`RACK_COUNT-1:0] rack_minor,
  output logic row_end_critical_quiet,
  output logic row_end_major,
  output logic row_end_minor,
  output logic audible_alarm,
  output logic [`LEVEL_COUNT-1:0] remote_maintenance_alarm,
  output logic [`LEVEL_COUNT-1:0] local_maintenance_alarm,
  output logic [`FAN_COUNT-1:0] fan_relay,
  output logic irq
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`LEVEL_COUNT+2:0] pins_s;
  logic sane_a_s;
  logic sane_b_s;
  logic master_b_s;
  logic [`LEVEL_COUNT-1:0] lamp_s;

  pin_sync #(.W(`LEVEL_COUNT + 3)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in({lamp_sense_pin, master_b_pin, sane_b_pin, sane_a_pin}),
    .pin_out(pins_s)
  );

  assign sane_a_s = pins_s[0]; // R16
  assign sane_b_s = pins_s[1]; // R16
  assign master_b_s = pins_s[2];
  assign lamp_s = pins_s[`LEVEL_COUNT+2:3];

  // ****************************************
  // register decode
  // ****************************************
  function automatic logic hit(input logic [`REG_ADDR_W-1:0] a, input logic [`REG_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic master_wr;
  assign master_wr = reg_wr && (reg_card == master_b_s); // R14

  // each card writes its own request bank; only the master's bank drives
  card_req_t bank_ff [2];
  logic [`FAN_COUNT-1:0] fan_ff;
  logic [`LEVEL_COUNT-1:0] lamp_stat_ff;
  logic [`LEVEL_COUNT-1:0] lamp_mask_ff;
  logic [`LEVEL_COUNT-1:0] lamp_evt;
  logic [`REG_DATA_W-1:0] rdata_ff;
  relay_state_t relay_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < 2; c++) begin
        bank_ff[c].rack <= `RACK_REQ_RST;
        bank_ff[c].aux <= `AUX_REQ_RST;
      end
    end else if (reg_wr) begin
      if (hit(reg_addr, `OFF_RACK_REQ)) begin
        bank_ff[reg_card].rack <= reg_wdata[3*`RACK_COUNT-1:0]; // R1
      end
      if (hit(reg_addr, `OFF_AUX_REQ)) begin
        bank_ff[reg_card].aux <= reg_wdata[7:0]; // R2
      end
    end
  end

  // fan relays are cleared by nrst; otherwise only a master write moves them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fan_ff <= `FAN_RST;
    end else if (master_wr && hit(reg_addr, `OFF_FAN)) begin
      fan_ff <= reg_wdata[`FAN_COUNT-1:0]; // R6 R13
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lamp_mask_ff <= `LAMP_MASK_RST;
    end else if (master_wr && hit(reg_addr, `OFF_LAMP_MASK)) begin
      lamp_mask_ff <= reg_wdata[`LEVEL_COUNT-1:0];
    end
  end

  // a new failure in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lamp_stat_ff <= '0;
    end else if (master_wr && hit(reg_addr, `OFF_LAMP_STATUS)) begin
      lamp_stat_ff <= (lamp_stat_ff & ~reg_wdata[`LEVEL_COUNT-1:0]) | lamp_evt; // R17
    end else begin
      lamp_stat_ff <= lamp_stat_ff | lamp_evt; // R17
    end
  end

  // level output: stays high until software clears or masks the bit
  assign irq = |(lamp_stat_ff & lamp_mask_ff);

  // ****************************************
  // register read
  // ****************************************
  logic [`REG_DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `OFF_RACK_REQ: nxt_rdata = {14'h0, bank_ff[reg_card].rack};
        `OFF_AUX_REQ: nxt_rdata = {24'h0, bank_ff[reg_card].aux};
        `OFF_FAN: nxt_rdata = {26'h0, fan_ff};
        `OFF_RELAY_STATE: nxt_rdata = {4'h0, relay_ff}; // R5
        `OFF_LAMP_STATUS: nxt_rdata = {29'h0, lamp_stat_ff};
        `OFF_LAMP_MASK: nxt_rdata = {29'h0, lamp_mask_ff};
        `OFF_CARD_STATE: nxt_rdata = {29'h0, master_b_s, sane_b_s, sane_a_s};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // registered, so read data stand exactly in the cycle after the strobe
  assign reg_rdata = rdata_ff;

  // ****************************************
  // alarm gating
  // ****************************************
  logic sane_any;
  card_req_t req;
  relay_state_t nxt_relay;

  assign sane_any = sane_a_s | sane_b_s;
  assign req = master_b_s ? bank_ff[1] : bank_ff[0]; // R14

  function automatic level_t gate_level(input level_t r, input logic sane);
    gate_level.critical = r.critical | !sane; // R9
    gate_level.major = r.major & sane; // R8
    gate_level.minor = r.minor & sane; // R8
  endfunction

  // row-end panel shows the worst state of any rack per level
  always_comb begin
    nxt_relay = '0;
    for (int i = 0; i < `RACK_COUNT; i++) begin
      nxt_relay.rack[i] = gate_level(req.rack[i], sane_any); // R1 R4
      nxt_relay.row_end = nxt_relay.row_end | nxt_relay.rack[i]; // R3
    end
    nxt_relay.audible = !sane_any | req.aux.audible; // R15 R2
    if (req.aux.gate) begin
      nxt_relay.remote = gate_level(req.aux.remote, sane_any); // R10
    end else begin
      nxt_relay.remote = '0; // R11
    end
    nxt_relay.local_lvl = gate_level(req.aux.local_lvl, sane_any); // R3
  end

  // reset leaves the critical relays energised; right after release the synced
  // sanity pins read insane for two edges, so the fail-safe path raises the alarm
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      relay_ff <= '0;
    end else begin
      relay_ff <= nxt_relay;
    end
  end

  // ****************************************
  // relay drive
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `RACK_COUNT; g++) begin : g_rack
      assign rack_critical_quiet[g] = ~relay_ff.rack[g].critical; // R7
      assign rack_major[g] = relay_ff.rack[g].major;
      assign rack_minor[g] = relay_ff.rack[g].minor;
    end
  endgenerate

  assign row_end_critical_quiet = ~relay_ff.row_end.critical; // R7
  assign row_end_major = relay_ff.row_end.major;
  assign row_end_minor = relay_ff.row_end.minor;
  assign audible_alarm = relay_ff.audible;
  assign remote_maintenance_alarm = relay_ff.remote;
  assign local_maintenance_alarm = relay_ff.local_lvl;
  assign fan_relay = fan_ff;

  // ****************************************
  // lamp failure sensing
  // ****************************************
  // relay contacts and opto need time to settle before missing current means a bad lamp
  generate
    for (g = 0; g < `LEVEL_COUNT; g++) begin : g_lamp
      logic [`LAMP_CNT_W-1:0] settle_ff;
      logic settled;
      assign settled = (settle_ff == `LAMP_CNT_W'(`LAMP_SETTLE_CYC));
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          settle_ff <= '0;
        end else if (!relay_ff.remote[g]) begin
          settle_ff <= '0;
        end else if (!settled) begin
          settle_ff <= settle_ff + `LAMP_CNT_W'(1);
        end
      end
      assign lamp_evt[g] = settled && relay_ff.remote[g] && !lamp_s[g]; // R12
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // checks guarded by $past(nrst) skip the edge at which the relay flops leave reset
  a_major_needs_sane: assert property (rack_major[0] |-> $past(sane_any)) // R8
    else $error("major alarm without a sane card");
  a_minor_needs_sane: assert property (rack_minor[0] |-> $past(sane_any)) // R8
    else $error("minor alarm without a sane card");
  a_major_on_request: assert property ($past(req.rack[0].major && sane_any) |-> rack_major[0]) // R8
    else $error("major request not driven");
  a_crit_both_insane: assert property ($past(nrst) && !$past(sane_any) |-> rack_critical_quiet == '0) // R9
    else $error("critical not raised with both cards insane");
  a_local_crit: assert property ($past(nrst) && !$past(sane_any) |-> local_maintenance_alarm[2]) // R9
    else $error("local critical not raised with both cards insane");
  a_crit_on_request: assert property ($past(req.rack[0].critical) |-> !rack_critical_quiet[0]) // R9
    else $error("critical request not driven");
  a_row_end_major: assert property (row_end_major == |rack_major) // R3
    else $error("row-end major differs from racks");
  a_row_end_crit: assert property (row_end_critical_quiet == &rack_critical_quiet) // R3
    else $error("row-end critical differs from racks");
  a_remote_blocked: assert property (!$past(req.aux.gate) |-> remote_maintenance_alarm == '0) // R11
    else $error("remote alarm leaked with gate off");
  a_remote_passed: assert property ($past(req.aux.gate && sane_any) |-> // R10
      remote_maintenance_alarm == $past(req.aux.remote))
    else $error("remote alarm not passed with gate on");
  a_audible_rule: assert property ($past(nrst) |-> audible_alarm == $past(!sane_any || req.aux.audible)) // R15
    else $error("audible alarm mismatch");

  // ****************************************
  // register bus checks
  // ****************************************
  a_fan_hold: assert property (!(master_wr && reg_addr == `OFF_FAN) |=> $stable(fan_relay)) // R6
    else $error("fan relay moved without master write");
  a_fan_write: assert property (master_wr && reg_addr == `OFF_FAN |=> // R13
      fan_relay == $past(reg_wdata[`FAN_COUNT-1:0]))
    else $error("fan write not applied");
  a_fan_standby: assert property (reg_wr && reg_card != master_b_s && reg_addr == `OFF_FAN |=> // R14
      $stable(fan_relay))
    else $error("standby card moved a fan relay");
  a_slave_ignored: assert property (reg_wr && reg_card != master_b_s && reg_addr == `OFF_LAMP_MASK |=> // R14
      $stable(lamp_mask_ff))
    else $error("standby card changed mask");
  a_relay_readback: assert property (reg_rd && reg_addr == `OFF_RELAY_STATE |=> // R5
      reg_rdata == {4'h0, $past(relay_ff)})
    else $error("relay readback wrong");

  // ****************************************
  // lamp failure checks
  // ****************************************
  a_lamp_flagged: assert property (lamp_evt[2] |=> lamp_stat_ff[2]) // R12
    else $error("lamp failure not flagged");
  a_lamp_needs_drive: assert property (lamp_evt[2] |-> remote_maintenance_alarm[2]) // R12
    else $error("lamp failure flagged on an idle circuit");
  a_lamp_latched: assert property (lamp_stat_ff[2] && !(master_wr && reg_addr == `OFF_LAMP_STATUS) |=> // R17
      lamp_stat_ff[2])
    else $error("lamp failure lost");

  // ****************************************
  // cover points
  // ****************************************
  c_lamp_fail: cover property (lamp_evt[2] ##1 irq);
  c_both_insane: cover property (!sane_any ##1 audible_alarm);
  c_master_swap: cover property ($changed(master_b_s) ##1 rack_major != '0);
  c_remote_gated: cover property (req.aux.gate ##1 remote_maintenance_alarm != '0);
  c_fan_write: cover property (master_wr && reg_addr == `OFF_FAN);
endmodule
`default_nettype wire

// file: core/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign pin_out = stage2_ff;
endmodule
`default_nettype wire
